/* rtl/sps_consts.svh */
`ifndef SPS_CONSTS_SVH
`define SPS_CONSTS_SVH
// Contract
// RL1 - the receive element count reads at status bits 28 to 24, meaningful with enhanced buffering on.
// RL2 - the transmit element count reads at status bits 20 to 16, meaningful with enhanced buffering on.
// RL3 - a detected frame error sets a clearable flag at bit 12, meaningful only in framed mode.
// RL4 - the activity flag at bit 11 is high while a transaction runs and low while idle.
// RL5 - a framed-mode transmit underrun sets bit 8, held until disable or a written zero.
// RL6 - the shifter empty flag at bit 7 is high whenever the shift register holds no data.
// RL7 - a received word dropped for lack of room sets bit 6, held until disable or a written zero.
// RL8 - the receive empty flag at bit 5 is high exactly when read and write pointers are equal.
// RL9 - status bits 31-29, 23-21, 15-13, 10-9 and 4 always read as zero.
// RL10 - bit 3 shows transmit empty (reset one), bit 1 transmit full, bit 0 receive full.
// RL11 - disabling the module returns all flags and counts to reset, transmit empty reading one.

// register byte offsets
`define SPS_OFF_CTRL 8'h00
`define SPS_OFF_STAT 8'h04
`define SPS_OFF_DATA 8'h08
`define SPS_OFF_IRQ_EN 8'h0c
`define SPS_OFF_IRQ_CLR 8'h10
`define SPS_OFF_IRQ_STAT 8'h14

// control register fields
`define SPS_CTRL_ON 0
`define SPS_CTRL_ENH 1
`define SPS_CTRL_FRM 2

// status register fields
`define SPS_ST_RXELM_LSB 24
`define SPS_ST_TXELM_LSB 16
`define SPS_ST_ELM_W 5
`define SPS_ST_FRAME_ERROR_FLAG 12
`define SPS_ST_BUSY 11
`define SPS_ST_TXUR 8
`define SPS_ST_SHEMPTY 7
`define SPS_ST_RXOV 6
`define SPS_ST_RXEMPTY 5
`define SPS_ST_TXEMPTY 3
`define SPS_ST_TXFULL 1
`define SPS_ST_RXFULL 0

// interrupt status, enable and clear fields
`define SPS_IRQ_RXWORD 0
`define SPS_IRQ_RXOV 1
`define SPS_IRQ_TXUR 2
`define SPS_IRQ_FRAME_ERROR_FLAG 3
`define SPS_IRQ_N 4

// reset values
`define SPS_RST_IRQ_EN 4'h0
`define SPS_RST_CTRL 3'h0

`endif

/* rtl/sps_mem.sv */
module sps_mem #(
   parameter int W = 8,
   parameter int AW = 4
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // storage port
   sps_mem_if.mem port
);
   logic [W-1:0] arr [2**AW];
   logic [W-1:0] rdata_q;

   // storage itself needs no reset; only the output register does
   always_ff @(posedge core_clk) begin
      if (port.we) begin
         arr[port.waddr] <= port.wdata;
      end
   end

   // registered read, one cycle behind the address
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= arr[port.raddr];
      end
   end

   assign port.rdata = rdata_q;
endmodule : sps_mem

/* rtl/sps_mem_if.sv */
interface sps_mem_if #(
   parameter int W = 8,
   parameter int AW = 4
);
   logic we;
   logic [AW-1:0] waddr;
   logic [W-1:0] wdata;
   logic [AW-1:0] raddr;
   logic [W-1:0] rdata;
   modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : sps_mem_if

/* rtl/sps_pkg.sv */
package sps_pkg;
   // link sequencer states, one-hot
   typedef enum logic [1:0] {
      SPS_IDLE = 2'b01,
      SPS_SHIFT = 2'b10
   } sps_link_t;
endpackage : sps_pkg

/* rtl/sps_status.sv */
`include "sps_consts.svh"

module sps_status
   import sps_pkg::*;
#(
   parameter int WORD_W = 8,
   parameter int AW = 4
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial link
   input wire logic sclk,
   input wire logic ss_n,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe,
   // interrupt
   output logic irq
);
   localparam int DEPTH = 2 ** AW;
   localparam int BC_W = $clog2(WORD_W);

   typedef struct packed {
      logic on;
      logic enh;
      logic frm;
      logic sclk_m;
      logic sclk_s;
      logic sclk_p;
      logic ss_m;
      logic ss_s;
      logic ss_p;
      logic mosi_m;
      logic mosi_s;
      sps_link_t lst;
      logic [BC_W-1:0] bit_cnt;
      logic [WORD_W-1:0] rx_sh;
      logic [WORD_W-1:0] tx_sh;
      logic sh_full;
      logic miso;
      logic [AW:0] rx_wp;
      logic [AW:0] rx_rp;
      logic [AW:0] tx_wp;
      logic [AW:0] tx_rp;
      logic frm_err;
      logic tx_ur;
      logic rx_ov;
      logic [`SPS_IRQ_N-1:0] irq_st;
      logic [`SPS_IRQ_N-1:0] irq_en;
      logic ack;
      logic [31:0] prdata;
   } sps_state_t;

   // sync stages idle high for ss_n so no false frame edge leaves reset
   localparam sps_state_t ST_RST = '{
      lst: SPS_IDLE,
      ss_m: 1'b1,
      ss_s: 1'b1,
      ss_p: 1'b1,
      irq_en: `SPS_RST_IRQ_EN,
      default: '0
   };

   sps_state_t q;
   sps_state_t d;

   sps_mem_if #(.W(WORD_W), .AW(AW)) rx_m ();
   sps_mem_if #(.W(WORD_W), .AW(AW)) tx_m ();

   logic [AW:0] cap;
   logic [AW:0] rx_cnt;
   logic [AW:0] tx_cnt;
   logic rx_full;
   logic tx_full;
   logic rx_empty;
   logic [31:0] stat;
   logic acc_first;
   logic acc_fin;
   logic mapped;
   logic rise;
   logic fall;
   logic frame_edge;
   logic start;
   logic done;
   logic load;
   logic rx_push;
   logic tx_push;
   logic [WORD_W-1:0] rx_word;
   logic [WORD_W-1:0] ld_word;
   logic [`SPS_IRQ_N-1:0] ev;

   // receive and transmit storage
   sps_mem #(.W(WORD_W), .AW(AW)) u_rx_mem (
      .core_clk(core_clk),
      .rst(rst),
      .port(rx_m.mem)
   );

   sps_mem #(.W(WORD_W), .AW(AW)) u_tx_mem (
      .core_clk(core_clk),
      .rst(rst),
      .port(tx_m.mem)
   );

   // occupancy; pointers carry a wrap bit so equal means empty
   always_comb begin
      cap = q.enh ? (AW + 1)'(DEPTH) : (AW + 1)'(1);
      rx_cnt = q.rx_wp - q.rx_rp;
      tx_cnt = q.tx_wp - q.tx_rp;
      rx_empty = (q.rx_wp == q.rx_rp); // [RL8]
      rx_full = (rx_cnt >= cap); // [RL10]
      tx_full = (tx_cnt >= cap); // [RL10]
   end

   // status word, unlisted bits stay zero
   always_comb begin
      stat = 32'h0000_0000; // [RL9]
      stat[`SPS_ST_RXELM_LSB +: `SPS_ST_ELM_W] = `SPS_ST_ELM_W'(rx_cnt); // [RL1]
      stat[`SPS_ST_TXELM_LSB +: `SPS_ST_ELM_W] = `SPS_ST_ELM_W'(tx_cnt); // [RL2]
      stat[`SPS_ST_FRAME_ERROR_FLAG] = q.frm_err; // [RL3]
      stat[`SPS_ST_BUSY] = (q.lst == SPS_SHIFT); // [RL4]
      stat[`SPS_ST_TXUR] = q.tx_ur; // [RL5]
      stat[`SPS_ST_SHEMPTY] = ~q.sh_full; // [RL6]
      stat[`SPS_ST_RXOV] = q.rx_ov; // [RL7]
      stat[`SPS_ST_RXEMPTY] = rx_empty; // [RL8]
      stat[`SPS_ST_TXEMPTY] = (tx_cnt == '0); // [RL10]
      stat[`SPS_ST_TXFULL] = tx_full; // [RL10]
      stat[`SPS_ST_RXFULL] = rx_full; // [RL10]
   end

   // address decode
   always_comb begin
      case (paddr)
         `SPS_OFF_CTRL,
         `SPS_OFF_STAT,
         `SPS_OFF_DATA,
         `SPS_OFF_IRQ_EN,
         `SPS_OFF_IRQ_CLR,
         `SPS_OFF_IRQ_STAT: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // link edges come from the second and third stages only
   assign rise = q.sclk_s & ~q.sclk_p;
   assign fall = ~q.sclk_s & q.sclk_p;
   assign frame_edge = ~q.ss_s & q.ss_p;

   // apb: first access cycle fetches, second completes with pready
   assign acc_first = psel & penable & ~q.ack;
   assign acc_fin = psel & penable & q.ack;

   // next-state logic for the whole block
   always_comb begin
      d = q;
      ev = '0;
      start = 1'b0;
      done = 1'b0;
      load = 1'b0;
      rx_push = 1'b0;
      tx_push = 1'b0;
      rx_word = {q.rx_sh[WORD_W-2:0], q.mosi_s};
      ld_word = tx_m.rdata;

      // two-stage synchronisers plus one stage for edge finding
      d.sclk_m = sclk;
      d.sclk_s = q.sclk_m;
      d.sclk_p = q.sclk_s;
      d.ss_m = ss_n;
      d.ss_s = q.ss_m;
      d.ss_p = q.ss_s;
      d.mosi_m = mosi;
      d.mosi_s = q.mosi_m;

      // register bus
      d.ack = acc_first;
      if (acc_first) begin
         case (paddr)
            `SPS_OFF_CTRL: d.prdata = {29'h0, q.frm, q.enh, q.on};
            `SPS_OFF_STAT: d.prdata = stat;
            `SPS_OFF_DATA: d.prdata = {{(32 - WORD_W){1'b0}}, rx_m.rdata};
            `SPS_OFF_IRQ_EN: d.prdata = {{(32 - `SPS_IRQ_N){1'b0}}, q.irq_en};
            `SPS_OFF_IRQ_STAT: d.prdata = {{(32 - `SPS_IRQ_N){1'b0}}, q.irq_st};
            default: d.prdata = 32'h0000_0000;
         endcase
      end
      if (acc_fin && pwrite) begin
         case (paddr)
            `SPS_OFF_CTRL: begin
               d.on = pwdata[`SPS_CTRL_ON];
               d.enh = pwdata[`SPS_CTRL_ENH];
               d.frm = pwdata[`SPS_CTRL_FRM];
            end
            `SPS_OFF_STAT: begin
               // a written zero clears, a written one is ignored
               if (!pwdata[`SPS_ST_FRAME_ERROR_FLAG]) d.frm_err = 1'b0; // [RL3]
               if (!pwdata[`SPS_ST_TXUR]) d.tx_ur = 1'b0; // [RL5]
               if (!pwdata[`SPS_ST_RXOV]) d.rx_ov = 1'b0; // [RL7]
            end
            `SPS_OFF_DATA: tx_push = q.on & ~tx_full;
            `SPS_OFF_IRQ_EN: d.irq_en = pwdata[`SPS_IRQ_N-1:0];
            `SPS_OFF_IRQ_CLR: d.irq_st = q.irq_st & ~pwdata[`SPS_IRQ_N-1:0];
            default: ;
         endcase
      end
      if (tx_push) begin
         d.tx_wp = q.tx_wp + (AW + 1)'(1);
      end
      // a read of the data register pops the oldest word
      if (acc_fin && !pwrite && paddr == `SPS_OFF_DATA && !rx_empty && q.on) begin
         d.rx_rp = q.rx_rp + (AW + 1)'(1);
      end

      // link sequencer
      if (q.frm && frame_edge) begin
         // frame pulse mid-word means the frame lost sync
         if (q.lst == SPS_SHIFT && q.bit_cnt != '0) begin
            d.frm_err = 1'b1; // [RL3]
            ev[`SPS_IRQ_FRAME_ERROR_FLAG] = 1'b1;
         end
         start = 1'b1;
      end else if (!q.frm && q.ss_s) begin
         // deselect aborts any partial word
         d.lst = SPS_IDLE;
         d.bit_cnt = '0;
         d.sh_full = 1'b0; // [RL6]
      end else if (!q.frm && q.lst == SPS_IDLE) begin
         start = 1'b1;
      end else begin
         case (q.lst)
            SPS_SHIFT: begin
               if (rise) begin
                  d.rx_sh = rx_word;
                  d.bit_cnt = q.bit_cnt + BC_W'(1);
                  if (q.bit_cnt == BC_W'(WORD_W - 1)) begin
                     done = 1'b1;
                  end
               end else if (fall && q.bit_cnt != '0) begin
                  d.tx_sh = {q.tx_sh[WORD_W-2:0], 1'b0};
                  d.miso = q.tx_sh[WORD_W-2];
               end
            end
            SPS_IDLE: ;
            default: d.lst = SPS_IDLE;
         endcase
      end

      // completed word: store it, or drop it when there is no room
      if (done) begin
         if (rx_full) begin
            d.rx_ov = 1'b1; // [RL7]
            ev[`SPS_IRQ_RXOV] = 1'b1;
         end else begin
            rx_push = 1'b1;
            d.rx_wp = q.rx_wp + (AW + 1)'(1);
            ev[`SPS_IRQ_RXWORD] = 1'b1;
         end
         if (q.frm) begin
            d.lst = SPS_IDLE;
            d.sh_full = 1'b0; // [RL6]
         end else begin
            load = 1'b1;
         end
      end
      load = load | start;

      // load the shifter from the transmit buffer at each word start
      if (load) begin
         d.lst = SPS_SHIFT;
         d.bit_cnt = '0;
         if (tx_cnt != '0) begin
            d.tx_sh = ld_word;
            d.miso = ld_word[WORD_W-1];
            d.tx_rp = q.tx_rp + (AW + 1)'(1);
            d.sh_full = 1'b1; // [RL6]
         end else begin
            d.tx_sh = '0;
            d.miso = 1'b0;
            d.sh_full = 1'b0; // [RL6]
            if (q.frm) begin
               d.tx_ur = 1'b1; // [RL5]
               ev[`SPS_IRQ_TXUR] = 1'b1;
            end
         end
      end

      // new events win over a clear in the same cycle
      d.irq_st = d.irq_st | ev;

      // disabled: everything but control, interrupt enables, bus and sync goes back to reset
      if (!q.on) begin
         d.lst = SPS_IDLE; // [RL11]
         d.bit_cnt = '0;
         d.rx_sh = '0;
         d.tx_sh = '0;
         d.sh_full = 1'b0;
         d.miso = 1'b0;
         d.rx_wp = '0;
         d.rx_rp = '0;
         d.tx_wp = '0;
         d.tx_rp = '0;
         d.frm_err = 1'b0;
         d.tx_ur = 1'b0;
         d.rx_ov = 1'b0;
         d.irq_st = ev & '0;
         rx_push = 1'b0;
      end
   end

   // storage ports; read addresses track the pointers
   assign rx_m.we = rx_push;
   assign rx_m.waddr = q.rx_wp[AW-1:0];
   assign rx_m.wdata = rx_word;
   assign rx_m.raddr = q.rx_rp[AW-1:0];
   assign tx_m.we = tx_push;
   assign tx_m.waddr = q.tx_wp[AW-1:0];
   assign tx_m.wdata = pwdata[WORD_W-1:0];
   assign tx_m.raddr = q.tx_rp[AW-1:0];

   // the single state register
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         q <= ST_RST;
      end else begin
         q <= d;
      end
   end

   // outputs
   assign prdata = q.prdata;
   assign pready = acc_fin;
   assign pslverr = acc_fin & ~mapped;
   assign miso = q.miso;
   assign miso_oe = q.on & (q.lst == SPS_SHIFT); // drive only inside a word
   assign irq = |(q.irq_st & q.irq_en);
endmodule : sps_status

/* verif/sps_peer.sv */
module sps_peer (
   // link lines
   output logic sclk,
   output logic ss_n,
   output logic mosi,
   input wire logic miso
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] rx_word = 8'h00;

   initial begin
      sclk = 1'b0;
      ss_n = 1'b1;
      mosi = 1'b0;
   end

   // n bits msb first; clock stands still outside the frame
   task automatic xfer(input int n, input logic [7:0] tx);
      #1 ss_n = 1'b0;
      #32;
      for (int i = 7; i > 7 - n; i--) begin
         mosi = tx[i];
         // sampled as sclk rises, as a mode 0 master does; the word load
         // after the last rise may already move miso before the fall
         #16 rx_word = {rx_word[6:0], miso};
         sclk = 1'b1;
         #16 sclk = 1'b0;
      end
      #16 mosi = ~mosi; // released line must not keep a stale level
      ss_n = 1'b1;
      #32;
   endtask : xfer
endmodule : sps_peer

/* verif/sps_status_assertions.sv */
`include "sps_consts.svh"

module sps_status_assertions (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // apb slave side
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // serial link and interrupt
   input wire logic sclk,
   input wire logic ss_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 100ps;
   logic st_rd;

   // a status read completing this cycle
   assign st_rd = pready && !pwrite && paddr == `SPS_OFF_STAT;

   property p_wait;
      @(posedge core_clk) disable iff (rst) $rose(penable) && psel |-> !pready ##1 pready;
   endproperty
   a_wait: assert property (p_wait) else $error("pready not after one wait state");

   property p_pulse;
      @(posedge core_clk) disable iff (rst) pready |=> !pready;
   endproperty
   a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");

   property p_err;
      @(posedge core_clk) disable iff (rst)
         pready |-> pslverr == (paddr > 8'h14 || paddr[1:0] != 2'h0);
   endproperty
   a_err: assert property (p_err) else $error("pslverr wrong for address");

   property p_rsv;
      @(posedge core_clk) disable iff (rst) st_rd |-> (prdata & 32'he0e0_e610) == 32'h0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved status bits set");

   property p_elm;
      @(posedge core_clk) disable iff (rst)
         st_rd |-> prdata[28:24] <= 5'h10 && prdata[20:16] <= 5'h10;
   endproperty
   a_elm: assert property (p_elm) else $error("element count beyond depth");

   property p_rxe;
      @(posedge core_clk) disable iff (rst) st_rd |-> prdata[5] == (prdata[28:24] == 5'h0);
   endproperty
   a_rxe: assert property (p_rxe) else $error("rx empty disagrees with count");

   property p_txe;
      @(posedge core_clk) disable iff (rst) st_rd |-> prdata[3] == (prdata[20:16] == 5'h0);
   endproperty
   a_txe: assert property (p_txe) else $error("tx empty disagrees with count");

   property p_full;
      @(posedge core_clk) disable iff (rst) st_rd && prdata[0] |-> !prdata[5];
   endproperty
   a_full: assert property (p_full) else $error("rx full and empty together");

   property p_quiet;
      @(posedge core_clk) disable iff (rst) $fell(rst) |-> !irq && !miso_oe;
   endproperty
   a_quiet: assert property (p_quiet) else $error("outputs active after reset");
endmodule : sps_status_assertions

bind sps_status sps_status_assertions chk_i (.core_clk(core_clk), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .sclk(sclk), .ss_n(ss_n), .mosi(mosi),
   .miso(miso), .miso_oe(miso_oe), .irq(irq));

/* verif/test_spi_status_flags.sv */
`include "sps_consts.svh"

module test_spi_status_flags;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rdat;
   logic pready, pslverr, sclk, ss_n, mosi, miso, miso_oe, irq, err;
   logic miso_pin;
   int n_errors = 0;
   int checked = 0;

   sps_status DUT (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso),
      .miso_oe(miso_oe), .irq(irq));
   // no pull on the line: a released pin shows the inverse of its last level
   assign miso_pin = miso_oe ? miso : ~miso;
   sps_peer peer (.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso_pin));

   always #2 core_clk = ~core_clk;

   task automatic end_of_test;
      if (n_errors == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   // one apb transfer, idle cycle after so strobes never toggle twice at once
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_errors++;
         $display("unexpected at %0t: no pready", $time);
         end_of_test();
      end
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdat & m, e);
   endtask : rd

   // reset value, read-only bits, unmapped place
   task automatic t_reset;
      rd(`SPS_OFF_STAT, 32'hffffffff, 32'h0000_00a8);
      apb(1'b0, 8'h18, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, `SPS_OFF_STAT, 32'hffffffff);
      rd(`SPS_OFF_STAT, 32'hffffffff, 32'h0000_00a8);
   endtask : t_reset

   // enhanced buffering: counts, activity while shifting
   task automatic t_buf;
      apb(1'b1, `SPS_OFF_CTRL, 32'h3);
      apb(1'b1, `SPS_OFF_DATA, 32'ha5);
      apb(1'b1, `SPS_OFF_DATA, 32'h3c);
      rd(`SPS_OFF_STAT, 32'h1f1f_00ab, 32'h0002_00a0);
      fork
         peer.xfer(8, 8'h5a);
         begin
            repeat (30) @(posedge core_clk);
            rd(`SPS_OFF_STAT, 32'h0000_0880, 32'h0000_0800);
            chk({31'h0, miso_oe}, 32'h1);
         end
      join
      chk({24'h0, peer.rx_word}, 32'ha5);
      chk({31'h0, miso_oe}, 32'h0);
      // the second word went into the shifter at the word end and died on deselect
      rd(`SPS_OFF_STAT, 32'h1f1f_0823, 32'h0100_0000);
      rd(`SPS_OFF_DATA, 32'hff, 32'h5a);
      rd(`SPS_OFF_STAT, 32'h1f00_0020, 32'h0000_0020);
   endtask : t_buf

   // single buffers: overflow, interrupt raise, mask, clear
   task automatic t_ovf;
      apb(1'b1, `SPS_OFF_CTRL, 32'h0);
      rd(`SPS_OFF_STAT, 32'hffffffff, 32'h0000_00a8);
      apb(1'b1, `SPS_OFF_CTRL, 32'h1);
      apb(1'b1, `SPS_OFF_IRQ_EN, 32'h2);
      apb(1'b1, `SPS_OFF_DATA, 32'h11);
      rd(`SPS_OFF_STAT, 32'h0000_000b, 32'h0000_0002);
      peer.xfer(8, 8'h81);
      peer.xfer(8, 8'h42);
      rd(`SPS_OFF_STAT, 32'h0000_0041, 32'h0000_0041);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, `SPS_OFF_IRQ_EN, 32'h0);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, `SPS_OFF_STAT, 32'h0);
      rd(`SPS_OFF_STAT, 32'h0000_0041, 32'h0000_0001);
      rd(`SPS_OFF_DATA, 32'hff, 32'h81);
      apb(1'b1, `SPS_OFF_IRQ_CLR, 32'hf);
      rd(`SPS_OFF_IRQ_STAT, 32'hf, 32'h0);
   endtask : t_ovf

   // framed mode: underrun, frame error, selective clear, disable
   task automatic t_frm;
      apb(1'b1, `SPS_OFF_CTRL, 32'h0);
      apb(1'b1, `SPS_OFF_CTRL, 32'h5);
      peer.xfer(8, 8'h00);
      rd(`SPS_OFF_STAT, 32'h0000_1100, 32'h0000_0100);
      peer.xfer(4, 8'hf0);
      peer.xfer(8, 8'h0f);
      rd(`SPS_OFF_STAT, 32'h0000_1100, 32'h0000_1100);
      apb(1'b1, `SPS_OFF_STAT, 32'h0000_0100);
      rd(`SPS_OFF_STAT, 32'h0000_1100, 32'h0000_0100);
      apb(1'b1, `SPS_OFF_CTRL, 32'h0);
      rd(`SPS_OFF_STAT, 32'hffffffff, 32'h0000_00a8);
   endtask : t_frm

   initial begin
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      t_reset();
      t_buf();
      t_ovf();
      t_frm();
      end_of_test();
   end
endmodule : test_spi_status_flags
